/* rtl/tiep_pkg.sv */
// Purpose: Shared constants for the top-level interrupt enable and pending
//          controller: register offsets, source bit positions, event bits.
// Assumes: 32-bit register data, byte addresses, 100 MHz system clock.
// Notes:   Bits above the last source are not implemented and read zero.
package tiep_pkg;

  // Register bus shape.
  localparam int          ADDR_W     = 12;
  localparam int          DATA_W     = 32;

  // Number of top-level sources.
  localparam int          NUM_SRC    = 17;

  // Register byte offsets.
  localparam logic [11:0] OFF_ENABLE_SET   = 12'h0100;
  localparam logic [11:0] OFF_ENABLE_CLEAR = 12'h0180;
  localparam logic [11:0] OFF_PENDING_SET  = 12'h0200;
  localparam logic [11:0] OFF_PENDING_CLR  = 12'h0280;
  localparam logic [11:0] OFF_EVT_STATUS   = 12'h0400;
  localparam logic [11:0] OFF_EVT_ENABLE   = 12'h0404;
  localparam logic [11:0] OFF_EVT_CLEAR    = 12'h0408;

  // Reset values.
  localparam logic [31:0] RST_REG    = 32'h0000_0000;
  localparam logic [16:0] RST_SRC    = 17'h0_0000;
  localparam logic [3:0]  RST_EVT    = 4'h0;

  // Source bit positions within every source register.
  localparam int          SRC_TIMER_ONE   = 0;
  localparam int          SRC_TIMER_TWO   = 1;
  localparam int          SRC_MANAGEMENT  = 2;
  localparam int          SRC_BASEBAND    = 3;
  localparam int          SRC_SLEEP_TIMER = 4;
  localparam int          SRC_SERIAL_ONE  = 5;
  localparam int          SRC_SERIAL_TWO  = 6;
  localparam int          SRC_SECURITY    = 7;
  localparam int          SRC_RADIO_TIMER = 8;
  localparam int          SRC_RADIO_TX    = 9;
  localparam int          SRC_RADIO_RX    = 10;
  localparam int          SRC_CONVERTER   = 11;
  localparam int          SRC_LINE_A      = 12;
  localparam int          SRC_LINE_B      = 13;
  localparam int          SRC_LINE_C      = 14;
  localparam int          SRC_LINE_D      = 15;
  localparam int          SRC_DEBUG       = 16;

  // Event status bits.
  localparam int          NUM_EVT         = 4;
  localparam int          EVT_HW_PEND     = 0;
  localparam int          EVT_SW_PEND     = 1;
  localparam int          EVT_CLR_BLOCKED = 2;
  localparam int          EVT_REQ_RISE    = 3;

endpackage

/* rtl/tiep_src_if.sv */
// Purpose: Carries per-source control strobes and state between the
//          register front end and the source bank.
// Assumes: All signals are synchronous to the system clock.
// Notes:   Vectors are indexed by source bit position.
`timescale 1ns/1ns
`default_nettype none
interface tiep_src_if #(parameter int N = 17);
  logic [N-1:0] level;
  logic [N-1:0] setEn;
  logic [N-1:0] clrEn;
  logic [N-1:0] setPend;
  logic [N-1:0] clrPend;
  logic [N-1:0] enable;
  logic [N-1:0] pending;

  modport ctrl (
    output level, setEn, clrEn, setPend, clrPend,
    input  enable, pending
  );
  modport bank (
    input  level, setEn, clrEn, setPend, clrPend,
    output enable, pending
  );
endinterface
`default_nettype wire

/* rtl/tiep_src_bank.sv */
// Purpose: Holds the enable and pending state of every top-level source.
// Assumes: Set and clear strobes for one state never come together.
// Notes:   A held source level keeps its pending bit set.
`timescale 1ns/1ns
`default_nettype none
module tiep_src_bank #(
  parameter int N = 17
) (
  input  wire logic clock,
  input  wire logic rst,
  tiep_src_if.bank  srcIf
);
  import tiep_pkg::*;

  genvar i;
  generate
    for (i = 0; i < N; i++) begin : g_src
      // Enable bit: one-writes set or clear it, zeros leave it.
      always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
          srcIf.enable[i] <= RST_SRC[i]; // R5
        end else if (srcIf.setEn[i]) begin
          srcIf.enable[i] <= 1'b1; // R1
        end else if (srcIf.clrEn[i]) begin
          srcIf.enable[i] <= 1'b0; // R2
        end
      end

      // Pending bit: a request or a one-write sets it and wins over clear.
      always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
          srcIf.pending[i] <= RST_SRC[i]; // R5
        end else begin
          srcIf.pending[i] <= srcIf.level[i] // R10
                           | srcIf.setPend[i] // R3
                           | (srcIf.pending[i] & ~srcIf.clrPend[i]); // R9
        end
      end
    end
  endgenerate

endmodule
`default_nettype wire

/* rtl/tiep_event_irq.sv */
// Purpose: Sticky event status with enable mask and one level interrupt.
// Assumes: Event inputs are one-cycle pulses from the controller.
// Notes:   An event in the same cycle as its clear keeps the bit set.
`timescale 1ns/1ns
`default_nettype none
module tiep_event_irq #(
  parameter int W = 4
) (
  input  wire logic         clock,
  input  wire logic         rst,
  input  wire logic [W-1:0] evtPulse,
  input  wire logic         enWrite,
  input  wire logic [W-1:0] enData,
  input  wire logic         clrWrite,
  input  wire logic [W-1:0] clrData,
  output logic      [W-1:0] status,
  output logic      [W-1:0] evtEnable,
  output logic              evtIrq
);
  import tiep_pkg::*;

  // Sticky status: set has priority over the write-one clear.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      status <= RST_EVT[W-1:0];
    end else begin
      status <= evtPulse | (status & ~(clrWrite ? clrData : '0));
    end
  end

  // Event enable mask, fully written by software.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      evtEnable <= RST_EVT[W-1:0];
    end else if (enWrite) begin
      evtEnable <= enData;
    end
  end

  // Level interrupt while any enabled status bit is set.
  assign evtIrq = |(status & evtEnable);

endmodule
`default_nettype wire

/* rtl/tiep_top.sv */
// Purpose: Top-level interrupt enable and pending controller for seventeen
//          sources, with a simple register port and request outputs.
// Assumes: Source inputs are synchronous levels; register strobes are
//          one cycle long and never both high together.
// Notes:   Read data is valid only in the cycle after the read strobe.
`timescale 1ns/1ns
`default_nettype none

// Behaviour
// (R1) Writing one to an enable-set bit enables that source only.
// (R2) Writing one to an enable-clear bit disables that source only.
// (R3) Writing one to a pending-set bit pends the source like a request.
// (R4) Zero bits written to set or clear registers change nothing.
// (R5) After reset all enables and pending bits are zero.
// (R6) Bit 16 is debug; bits 15 to 12 are external lines D to A.
// (R7) Bit 11 converter; 10, 9, 8 radio receive, transmit, timer; 7 security.
// (R8) Bits 6..0: serial two, one, sleep, baseband, management, timers.
// (R9) Writing one to a pending-clear bit unpends that source; zero nothing.
// (R10) Source requests are levels; pending holds while the level stays.
// (R11) Bits 31 to 17 read zero and ignore writes.
// (R12) Both enable registers read enable state; pending-set reads pending.
module tiep_top #(
  parameter int ADDR_W = tiep_pkg::ADDR_W
) (
  input  wire logic                    clock,
  input  wire logic                    rst,
  input  wire logic [ADDR_W-1:0]       regAddr,
  input  wire logic [tiep_pkg::DATA_W-1:0] regWdata,
  input  wire logic                    regWrite,
  input  wire logic                    regRead,
  output logic      [tiep_pkg::DATA_W-1:0] regRdata,
  input  wire logic                    debugSource,
  input  wire logic                    externalLineD,
  input  wire logic                    externalLineC,
  input  wire logic                    externalLineB,
  input  wire logic                    externalLineA,
  input  wire logic                    converterSource,
  input  wire logic                    radioReceiveSource,
  input  wire logic                    radioTransmitSource,
  input  wire logic                    radioTimerSource,
  input  wire logic                    securityEngineSource,
  input  wire logic                    serialCtrlTwoSource,
  input  wire logic                    serialCtrlOneSource,
  input  wire logic                    sleepTimerSource,
  input  wire logic                    basebandSource,
  input  wire logic                    managementSource,
  input  wire logic                    generalTimerTwoSource,
  input  wire logic                    generalTimerOneSource,
  output logic      [tiep_pkg::NUM_SRC-1:0] irqRequest,
  output logic                         eventIrq
);
  import tiep_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Declarations.
  ////////////////////////////////////////////////////////////////////////////

  tiep_src_if #(.N(NUM_SRC)) srcIf ();

  logic [NUM_SRC-1:0] srcLevel;
  logic [NUM_SRC-1:0] wrBits;
  logic [NUM_SRC-1:0] reqNow;
  logic [NUM_SRC-1:0] reqPrev;
  logic [NUM_EVT-1:0] evtPulse;
  logic [NUM_EVT-1:0] evtStatus;
  logic [NUM_EVT-1:0] evtEnable;
  logic [DATA_W-1:0]  next_regRdata;
  logic               wrEnableSet;
  logic               wrEnableClear;
  logic               wrPendingSet;
  logic               wrPendingClr;
  logic               wrEvtEnable;
  logic               wrEvtClear;

  ////////////////////////////////////////////////////////////////////////////
  // Helper functions.
  ////////////////////////////////////////////////////////////////////////////

  // True when the bus address selects the given register offset.
  function automatic logic addrHit(
    input logic [ADDR_W-1:0] addr,
    input logic [11:0]       offset
  );
    addrHit = (addr == ADDR_W'(offset));
  endfunction

  // Widens a source vector to a bus word with upper bits zero.
  function automatic logic [DATA_W-1:0] srcWord(
    input logic [NUM_SRC-1:0] bits
  );
    srcWord = {{(DATA_W - NUM_SRC){1'b0}}, bits}; // R11
  endfunction

  // Widens an event vector to a bus word with upper bits zero.
  function automatic logic [DATA_W-1:0] evtWord(
    input logic [NUM_EVT-1:0] bits
  );
    evtWord = {{(DATA_W - NUM_EVT){1'b0}}, bits};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Source assembly: each request line lands on its fixed bit.
  ////////////////////////////////////////////////////////////////////////////

  // External lines and debug occupy the upper bits.
  always_comb begin
    srcLevel                  = '0;
    srcLevel[SRC_DEBUG]       = debugSource; // R6
    srcLevel[SRC_LINE_D]      = externalLineD; // R6
    srcLevel[SRC_LINE_C]      = externalLineC; // R6
    srcLevel[SRC_LINE_B]      = externalLineB; // R6
    srcLevel[SRC_LINE_A]      = externalLineA; // R6
    srcLevel[SRC_CONVERTER]   = converterSource; // R7
    srcLevel[SRC_RADIO_RX]    = radioReceiveSource; // R7
    srcLevel[SRC_RADIO_TX]    = radioTransmitSource; // R7
    srcLevel[SRC_RADIO_TIMER] = radioTimerSource; // R7
    srcLevel[SRC_SECURITY]    = securityEngineSource; // R7
    srcLevel[SRC_SERIAL_TWO]  = serialCtrlTwoSource; // R8
    srcLevel[SRC_SERIAL_ONE]  = serialCtrlOneSource; // R8
    srcLevel[SRC_SLEEP_TIMER] = sleepTimerSource; // R8
    srcLevel[SRC_BASEBAND]    = basebandSource; // R8
    srcLevel[SRC_MANAGEMENT]  = managementSource; // R8
    srcLevel[SRC_TIMER_TWO]   = generalTimerTwoSource; // R8
    srcLevel[SRC_TIMER_ONE]   = generalTimerOneSource; // R8
  end

  // Peripheral levels drive the bank directly; no edge is taken.
  assign srcIf.level = srcLevel; // R10

  ////////////////////////////////////////////////////////////////////////////
  // Write decode.
  ////////////////////////////////////////////////////////////////////////////

  // Only the implemented low bits of the write data are looked at.
  assign wrBits = regWdata[NUM_SRC-1:0]; // R11

  // One write pulse for each writable register; event status has none.
  assign wrEnableSet   = regWrite && addrHit(regAddr, OFF_ENABLE_SET);
  assign wrEnableClear = regWrite && addrHit(regAddr, OFF_ENABLE_CLEAR);
  assign wrPendingSet  = regWrite && addrHit(regAddr, OFF_PENDING_SET);
  assign wrPendingClr  = regWrite && addrHit(regAddr, OFF_PENDING_CLR);
  assign wrEvtEnable   = regWrite && addrHit(regAddr, OFF_EVT_ENABLE);
  assign wrEvtClear    = regWrite && addrHit(regAddr, OFF_EVT_CLEAR);

  // Per-bit strobes: a zero data bit yields no strobe at all.
  assign srcIf.setEn   = wrEnableSet   ? wrBits : '0; // R1 R4
  assign srcIf.clrEn   = wrEnableClear ? wrBits : '0; // R2 R4
  assign srcIf.setPend = wrPendingSet  ? wrBits : '0; // R3 R4
  assign srcIf.clrPend = wrPendingClr  ? wrBits : '0; // R9

  ////////////////////////////////////////////////////////////////////////////
  // Source bank holding enable and pending state.
  ////////////////////////////////////////////////////////////////////////////

  tiep_src_bank #(
    .N     (NUM_SRC)
  ) u_bank (
    .clock (clock),
    .rst   (rst),
    .srcIf (srcIf)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Requests presented to the core.
  ////////////////////////////////////////////////////////////////////////////

  // A source requests service while it is both pending and enabled.
  assign reqNow     = srcIf.pending & srcIf.enable;
  assign irqRequest = reqNow;

  // Previous request vector, used to spot newly raised requests.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      reqPrev <= RST_SRC;
    end else begin
      reqPrev <= reqNow;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Controller events.
  ////////////////////////////////////////////////////////////////////////////

  // Events raised by source and software activity, one cycle each.
  always_comb begin
    evtPulse = '0;
    // A hardware level arrives at a source that is not yet pending.
    evtPulse[EVT_HW_PEND]     = |(srcLevel & ~srcIf.pending);
    // Software pends a source that was not pending.
    evtPulse[EVT_SW_PEND]     = |(srcIf.setPend & ~srcIf.pending);
    // An unpend write meets a source whose level is still held.
    evtPulse[EVT_CLR_BLOCKED] = |(srcIf.clrPend & srcLevel & srcIf.pending);
    // A new request is presented to the core.
    evtPulse[EVT_REQ_RISE]    = |(reqNow & ~reqPrev);
  end

  tiep_event_irq #(
    .W         (NUM_EVT)
  ) u_evt (
    .clock     (clock),
    .rst       (rst),
    .evtPulse  (evtPulse),
    .enWrite   (wrEvtEnable),
    .enData    (regWdata[NUM_EVT-1:0]),
    .clrWrite  (wrEvtClear),
    .clrData   (regWdata[NUM_EVT-1:0]),
    .status    (evtStatus),
    .evtEnable (evtEnable),
    .evtIrq    (eventIrq)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Read path.
  ////////////////////////////////////////////////////////////////////////////

  // Read mux; unmapped and write-only offsets return zero.
  always_comb begin
    next_regRdata = RST_REG;
    if (regRead) begin
      if (addrHit(regAddr, OFF_ENABLE_SET)) begin
        next_regRdata = srcWord(srcIf.enable); // R12
      end else if (addrHit(regAddr, OFF_ENABLE_CLEAR)) begin
        next_regRdata = srcWord(srcIf.enable); // R12
      end else if (addrHit(regAddr, OFF_PENDING_SET)) begin
        next_regRdata = srcWord(srcIf.pending); // R12
      end else if (addrHit(regAddr, OFF_PENDING_CLR)) begin
        next_regRdata = srcWord(srcIf.pending);
      end else if (addrHit(regAddr, OFF_EVT_STATUS)) begin
        next_regRdata = evtWord(evtStatus);
      end else if (addrHit(regAddr, OFF_EVT_ENABLE)) begin
        next_regRdata = evtWord(evtEnable);
      end else begin
        next_regRdata = RST_REG;
      end
    end
  end

  // Read data register: valid in the cycle after the strobe only.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      regRdata <= RST_REG; // R5
    end else begin
      regRdata <= next_regRdata;
    end
  end

endmodule
`default_nettype wire

/* tb/tiep_assertions.sv */
// Purpose: Checks register, source and request relations at the top ports.
// Assumes: One clock domain, asynchronous active-high reset.
// Notes:   A shadow enable word judges readback and masking.
`timescale 1ns/1ns
`default_nettype none
module tiep_assertions #(
  parameter int ADDR_W = 12
) (
  input wire logic                         clock,
  input wire logic                         rst,
  input wire logic [ADDR_W-1:0]            regAddr,
  input wire logic [tiep_pkg::DATA_W-1:0]  regWdata,
  input wire logic                         regWrite,
  input wire logic                         regRead,
  input wire logic [tiep_pkg::DATA_W-1:0]  regRdata,
  input wire logic                         debugSource,
  input wire logic                         generalTimerOneSource,
  input wire logic [tiep_pkg::NUM_SRC-1:0] irqRequest
);
  import tiep_pkg::*;
  logic [NUM_SRC-1:0] enShadow;
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////////////
  // Shadow of the enable word, built from set and clear writes.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      enShadow <= RST_SRC;
    end else if (regWrite && regAddr == OFF_ENABLE_SET) begin
      enShadow <= enShadow | regWdata[NUM_SRC-1:0];
    end else if (regWrite && regAddr == OFF_ENABLE_CLEAR) begin
      enShadow <= enShadow & ~regWdata[NUM_SRC-1:0];
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // Relations between strobes, sources, read data and requests.
  enable_read_a: assert property (
    regRead && (regAddr == OFF_ENABLE_SET || regAddr == OFF_ENABLE_CLEAR)
    |=> regRdata == {15'h0, $past(enShadow)})
    else $error("enable readback differs from written state");
  irq_masked_a: assert property (
    (irqRequest & ~enShadow) == '0)
    else $error("request raised for a disabled source");
  level_pend_a: assert property (
    generalTimerOneSource ##1 enShadow[SRC_TIMER_ONE]
    |-> irqRequest[SRC_TIMER_ONE])
    else $error("held source level gave no request");
  pend_set_a: assert property (
    regWrite && regAddr == OFF_PENDING_SET && regWdata[SRC_DEBUG]
    ##1 enShadow[SRC_DEBUG] |-> irqRequest[SRC_DEBUG])
    else $error("pending-set write gave no request");
  pend_clear_a: assert property (
    regWrite && regAddr == OFF_PENDING_CLR && regWdata[SRC_TIMER_ONE]
    && !generalTimerOneSource |=> !irqRequest[SRC_TIMER_ONE])
    else $error("pending-clear write left the request up");
  zero_write_a: assert property (
    regWrite && !regWdata[SRC_DEBUG] && irqRequest[SRC_DEBUG]
    |=> irqRequest[SRC_DEBUG])
    else $error("zero bit written changed a request");
  reserved_zero_a: assert property (
    regRead |=> regRdata[DATA_W-1:NUM_SRC] == '0)
    else $error("unused read bits not zero");
  read_idle_a: assert property (
    !regRead |=> regRdata == '0)
    else $error("read data outside the read slot");
  cover property (regWrite && regAddr == OFF_PENDING_CLR);
  cover property (generalTimerOneSource && irqRequest[SRC_TIMER_ONE]);
  cover property ($rose(irqRequest[SRC_DEBUG]));
endmodule
`default_nettype wire

/* tb/tiep_src_model.sv */
// Purpose: Peripheral flags that feed the top-level source levels.
// Assumes: Raise and acknowledge are one-cycle pulses from the bench.
// Notes:   A flag raised while acknowledged stays set.
`timescale 1ns/1ns
`default_nettype none
module tiep_src_model (
  input  wire logic                         clock,
  input  wire logic                         rst,
  input  wire logic [tiep_pkg::NUM_SRC-1:0] raise,
  input  wire logic [tiep_pkg::NUM_SRC-1:0] ack,
  output logic      [tiep_pkg::NUM_SRC-1:0] level
);
  import tiep_pkg::*;
  // Each flag holds its level until software acknowledges it.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      level <= RST_SRC;
    end else begin
      level <= (level & ~ack) | raise;
    end
  end
endmodule
`default_nettype wire

/* tb/tb.sv */
// Purpose: Self-checking bench for the interrupt enable and pending block.
// Assumes: Fixed one-cycle write effect and read latency.
// Notes:   Source levels come from the flag model.
`timescale 1ns/1ns
`default_nettype none
module tb;
  import tiep_pkg::*;
  logic               clock;
  logic               rst;
  logic               regWrite;
  logic               regRead;
  logic               eventIrq;
  logic [11:0]        regAddr;
  logic [DATA_W-1:0]  regWdata;
  logic [DATA_W-1:0]  regRdata;
  logic [NUM_SRC-1:0] src;
  logic [NUM_SRC-1:0] raise;
  logic [NUM_SRC-1:0] ack;
  logic [NUM_SRC-1:0] irqRequest;
  int                 fail_count = 0;
  int                 checked = 0;
  ////////////////////////////////////////////////////////////////////////
  // Design, flag model and clock.
  tiep_top dut_u (.clock(clock), .rst(rst), .regAddr(regAddr),
    .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
    .regRdata(regRdata), .debugSource(src[16]), .externalLineD(src[15]),
    .externalLineC(src[14]), .externalLineB(src[13]),
    .externalLineA(src[12]), .converterSource(src[11]),
    .radioReceiveSource(src[10]), .radioTransmitSource(src[9]),
    .radioTimerSource(src[8]), .securityEngineSource(src[7]),
    .serialCtrlTwoSource(src[6]), .serialCtrlOneSource(src[5]),
    .sleepTimerSource(src[4]), .basebandSource(src[3]),
    .managementSource(src[2]), .generalTimerTwoSource(src[1]),
    .generalTimerOneSource(src[0]), .irqRequest(irqRequest),
    .eventIrq(eventIrq));
  tiep_src_model flags_u (.clock(clock), .rst(rst), .raise(raise),
    .ack(ack), .level(src));
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  ////////////////////////////////////////////////////////////////////////
  // Compare, register access and closing tasks.
  task automatic chk(input logic [31:0] got, exp, input string what);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got,
        exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    regWrite <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge clock);
    regWrite <= 1'b0;
    @(posedge clock);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e,
                    input string what);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge clock);
    regRead <= 1'b0;
    #1 chk(regRdata, e, what);
    @(posedge clock);
  endtask
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  // Scenarios.
  task automatic t_reset();
    rd(OFF_ENABLE_SET, 32'h0, "enable after reset");
    rd(OFF_PENDING_SET, 32'h0, "pending after reset");
    chk(32'(irqRequest), 32'h0, "request after reset");
  endtask
  task automatic t_enable();
    wr(OFF_ENABLE_SET, 32'hFFFF_FFFF);
    rd(OFF_ENABLE_CLEAR, 32'h0001_FFFF, "enable all");
    wr(OFF_ENABLE_CLEAR, 32'h0001_0020);
    rd(OFF_ENABLE_SET, 32'h0000_FFDF, "disable two");
    wr(OFF_ENABLE_SET, 32'h0);
    wr(OFF_ENABLE_CLEAR, 32'h0);
    rd(OFF_ENABLE_SET, 32'h0000_FFDF, "zero writes");
    wr(OFF_ENABLE_SET, 32'h0001_0020);
  endtask
  task automatic t_map();
    for (int i = 0; i < NUM_SRC; i++) begin
      raise <= 17'h0_0001 << i;
      @(posedge clock);
      raise <= '0;
      @(posedge clock);
      #1 chk(32'(irqRequest), 32'h0000_0001 << i, "source bit");
      @(posedge clock);
      wr(OFF_PENDING_CLR, 32'h0000_0001 << i);
      rd(OFF_PENDING_SET, 32'h0000_0001 << i, "held level");
      ack <= 17'h0_0001 << i;
      @(posedge clock);
      ack <= '0;
      @(posedge clock);
      wr(OFF_PENDING_CLR, 32'h0000_0001 << i);
      rd(OFF_PENDING_SET, 32'h0, "unpend source");
    end
  endtask
  task automatic t_pend();
    wr(OFF_PENDING_SET, 32'h0001_0001);
    rd(OFF_PENDING_SET, 32'h0001_0001, "software pend");
    rd(OFF_PENDING_CLR, 32'h0001_0001, "pending via clear");
    chk(32'(irqRequest), 32'h0001_0001, "pend request");
    wr(OFF_PENDING_CLR, 32'h0);
    rd(OFF_PENDING_SET, 32'h0001_0001, "zero clear");
    wr(OFF_PENDING_CLR, 32'h0000_0001);
    rd(OFF_PENDING_SET, 32'h0001_0000, "one clear");
    wr(OFF_ENABLE_CLEAR, 32'h0001_0000);
    chk(32'(irqRequest), 32'h0, "masked request");
    wr(OFF_PENDING_CLR, 32'h0001_0000);
    rd(OFF_ENABLE_CLEAR, 32'h0000_FFFF, "enable word");
  endtask
  task automatic t_event();
    rd(OFF_EVT_STATUS, 32'h0000_000F, "event status");
    wr(OFF_EVT_ENABLE, 32'h0000_0004);
    chk(32'(eventIrq), 32'h1, "event line up");
    wr(OFF_EVT_CLEAR, 32'h0000_000F);
    chk(32'(eventIrq), 32'h0, "event line cleared");
    wr(OFF_EVT_ENABLE, 32'h0);
    wr(OFF_ENABLE_CLEAR, 32'hFFFF_FFFF);
    wr(OFF_PENDING_SET, 32'h0000_0001);
    rd(OFF_EVT_STATUS, 32'h0000_0002, "software pend event");
    chk(32'(eventIrq), 32'h0, "masked event");
    wr(OFF_EVT_ENABLE, 32'h0000_0002);
    chk(32'(eventIrq), 32'h1, "unmasked event");
    rd(OFF_EVT_ENABLE, 32'h0000_0002, "event enable readback");
    rd(OFF_EVT_CLEAR, 32'h0, "clear reads zero");
    wr(12'h300, 32'hFFFF_FFFF);
    rd(12'h300, 32'h0, "unmapped read");
    rd(OFF_ENABLE_SET, 32'h0, "unmapped write");
    wr(OFF_EVT_CLEAR, 32'h0000_0002);
    chk(32'(eventIrq), 32'h0, "event cleared");
    wr(OFF_ENABLE_SET, 32'h0000_0001);
    rst <= 1'b1;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    rd(OFF_PENDING_SET, 32'h0, "pending after reset");
    rd(OFF_ENABLE_SET, 32'h0, "enable after reset");
  endtask
  ////////////////////////////////////////////////////////////////////////
  // Main sequence and hang guard.
  initial begin
    rst = 1'b1;
    regWrite = 1'b0;
    regRead = 1'b0;
    regAddr = '0;
    regWdata = '0;
    raise = '0;
    ack = '0;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    t_reset();
    t_enable();
    t_map();
    t_pend();
    t_event();
    end_sim();
  end
  initial begin
    repeat (20000) @(posedge clock);
    fail_count++;
    end_sim();
  end
endmodule
bind tiep_top tiep_assertions #(.ADDR_W(ADDR_W)) chk_u (.clock(clock),
  .rst(rst), .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite),
  .regRead(regRead), .regRdata(regRdata), .debugSource(debugSource),
  .generalTimerOneSource(generalTimerOneSource), .irqRequest(irqRequest));
`default_nettype wire
